//--- design/dtc_pkg.sv
// Constants for the dual timer/counter: register map, field layout, timing.
// Assumes a 10 MHz oscillator clock and an APB master with 32-bit data.
package dtc_pkg;
    // Byte addresses of the registers
    localparam logic [7:0]  MODE_OFFSET      = 8'h00;
    localparam logic [7:0]  RUN_OFFSET       = 8'h04;
    localparam logic [7:0]  OVF_OFFSET       = 8'h08;
    localparam logic [7:0]  COUNT0_OFFSET    = 8'h0C;
    localparam logic [7:0]  COUNT1_OFFSET    = 8'h10;
    // Mode register: timer 0 in the low nibble, timer 1 in the high nibble
    localparam int          MODE_LOW_POS     = 0;
    localparam int          MODE_HIGH_POS    = 1;
    localparam int          COUNT_SEL_POS    = 2;
    localparam int          GATE_EN_POS      = 3;
    localparam int          TIMER1_FIELD_POS = 4;
    // Run and overflow registers: bit 0 timer 0, bit 1 timer 1
    localparam int          UNIT0_POS        = 0;
    localparam int          UNIT1_POS        = 1;
    // Reset values
    localparam logic [7:0]  MODE_RESET       = 8'h00;
    localparam logic [1:0]  RUN_RESET        = 2'h0;
    localparam logic [1:0]  OVF_RESET        = 2'h0;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    // Mode field encodings
    localparam logic [1:0]  MODE_PRESCALE    = 2'h0;
    localparam logic [1:0]  MODE_WIDE        = 2'h1;
    localparam logic [1:0]  MODE_RELOAD      = 2'h2;
    localparam logic [1:0]  MODE_SPLIT       = 2'h3;
    // Prescaler in mode 0 takes the low five bits of the low byte
    localparam logic [4:0]  PRESCALE_MAX     = 5'h1F;
    // Timing: the oscillator drives sys_clk, a machine cycle is 12 periods
    localparam int          SYS_CLK_PERIOD_NS = 100;
    localparam int          OSC_PER_MACHINE  = 12;
    localparam logic [3:0]  MC_LAST          = 4'(OSC_PER_MACHINE - 1);
endpackage : dtc_pkg

//--- design/dtc_timer_counter.sv
// Two timer/counters with four modes, external count and gate pins, on APB.
// Assumes count and gate pins are asynchronous; APB runs on sys_clk.
//
// Behaviour
// - Each timer/counter offers four modes picked by a two-bit mode field.
// - Mode 0 is an 8-bit counter fed through a divide-by-32 prescaler.
// - Mode 3 splits timer 0 into two 8-bit halves and stops timer 1.
// - In timer function the count rises once per machine cycle, oscillator over 12.
// - In counter function the count rises on each falling edge of the count pin.
// - Edge detection spans two machine cycles, so the top external rate is over 24.
// - A gate input can be enabled to let counting run only while it is high.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module dtc_timer_counter (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_input_zero,
    input  wire logic        count_input_one,
    input  wire logic        gate_input_zero,
    input  wire logic        gate_input_one
);
    import dtc_pkg::*;

    // Step of one 16-bit unit in modes 0 to 2; returns {overflow, high, low}
    function automatic logic [16:0] dtc_step(input logic [1:0] mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [13:0] p13;
        logic [16:0] w17;
        logic [8:0]  b9;
        p13 = 14'h0000;
        w17 = 17'h00000;
        b9  = 9'h000;
        case (mode)
            MODE_PRESCALE: begin
                p13 = {1'b0, hi, lo[4:0]} + 14'h0001;
                dtc_step = {p13[13], p13[12:5], lo[7:5], p13[4:0]};
            end
            MODE_WIDE: begin
                w17 = {1'b0, hi, lo} + 17'h00001;
                dtc_step = w17;
            end
            MODE_RELOAD: begin
                b9 = {1'b0, lo} + 9'h001;
                dtc_step = {b9[8], hi, (b9[8] ? hi : b9[7:0])};
            end
            default: begin
                b9 = {1'b0, lo} + 9'h001;
                dtc_step = {b9[8], hi, b9[7:0]};
            end
        endcase
    endfunction : dtc_step

    // Pin synchronisers
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= {gate_input_one, gate_input_zero, count_input_one, count_input_zero};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Machine-cycle divider and once-per-cycle pin sampling
    logic [3:0] mc_cnt_q;
    logic [3:0] mc_cnt_d;
    logic [1:0] cnt_smp_q;
    logic [1:0] cnt_smp_d;
    logic       mc_tick;
    logic [1:0] fall;

    always_comb begin
        mc_tick   = (mc_cnt_q == MC_LAST);
        mc_cnt_d  = mc_tick ? 4'h0 : mc_cnt_q + 4'h1;
        cnt_smp_d = mc_tick ? pin_sync_q[1:0] : cnt_smp_q;
        // Previous sample high and this one low: two machine cycles per edge
        fall      = mc_tick ? (cnt_smp_q & ~pin_sync_q[1:0]) : 2'h0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_cnt_q  <= 4'h0;
            cnt_smp_q <= 2'h0;
        end else begin
            mc_cnt_q  <= mc_cnt_d;
            cnt_smp_q <= cnt_smp_d;
        end
    end

    // Registers and counting
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic [1:0]  run_q;
    logic [1:0]  run_d;
    logic [1:0]  ovf_q;
    logic [1:0]  ovf_d;
    logic [15:0] cnt0_q;
    logic [15:0] cnt0_d;
    logic [15:0] cnt1_q;
    logic [15:0] cnt1_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic [1:0]  mode0;
    logic [1:0]  mode1;
    logic [1:0]  go;
    logic [1:0]  tick;
    logic        split;
    logic        tick0_hi;
    logic        wr_acc;
    logic        rd_setup;
    logic        hit;
    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0]  hi0_inc;

    always_comb begin
        mode0    = mode_q[MODE_HIGH_POS:MODE_LOW_POS];
        mode1    = mode_q[TIMER1_FIELD_POS+MODE_HIGH_POS:TIMER1_FIELD_POS];
        split    = (mode0 == MODE_SPLIT);
        // Gate enabled: count only while the gate pin is high
        go[0]    = run_q[UNIT0_POS] & (~mode_q[GATE_EN_POS] | pin_sync_q[2]);
        go[1]    = run_q[UNIT1_POS]
                   & (~mode_q[TIMER1_FIELD_POS+GATE_EN_POS] | pin_sync_q[3]);
        tick[0]  = go[0] & (mode_q[COUNT_SEL_POS] ? fall[0] : mc_tick);
        tick[1]  = go[1] & (mode1 != MODE_SPLIT)
                   & (mode_q[TIMER1_FIELD_POS+COUNT_SEL_POS] ? fall[1] : mc_tick);
        // Split mode: high byte of timer 0 is a plain timer borrowing run and flag of timer 1
        tick0_hi = split & run_q[UNIT1_POS] & mc_tick;
        step0    = dtc_step(mode0, cnt0_q[7:0], cnt0_q[15:8]);
        step1    = dtc_step(mode1, cnt1_q[7:0], cnt1_q[15:8]);
        hi0_inc  = {1'b0, cnt0_q[15:8]} + 9'h001;
        wr_acc   = psel & penable & pwrite;
        rd_setup = psel & ~penable;
        hit      = (paddr == MODE_OFFSET) || (paddr == RUN_OFFSET) || (paddr == OVF_OFFSET)
                   || (paddr == COUNT0_OFFSET) || (paddr == COUNT1_OFFSET);

        mode_d = mode_q;
        run_d  = run_q;
        ovf_d  = ovf_q;
        cnt0_d = cnt0_q;
        cnt1_d = cnt1_q;
        if (tick[0]) begin
            cnt0_d[7:0] = step0[7:0];
            if (!split) begin
                cnt0_d[15:8] = step0[15:8];
            end
        end
        if (tick0_hi) begin
            cnt0_d[15:8] = hi0_inc[7:0];
        end
        if (tick[1]) begin
            cnt1_d = step1[15:0];
        end
        // Write-one clears an overflow flag; a new overflow in that cycle wins
        if (wr_acc && paddr == OVF_OFFSET) begin
            ovf_d = ovf_q & ~pwdata[1:0];
        end
        if (tick[0] && step0[16]) begin
            ovf_d[UNIT0_POS] = 1'b1;
        end
        if ((tick0_hi && hi0_inc[8]) || (tick[1] && step1[16])) begin
            ovf_d[UNIT1_POS] = 1'b1;
        end
        // A software write to a count wins over a same-cycle increment
        if (wr_acc) begin
            case (paddr)
                MODE_OFFSET:   mode_d = pwdata[7:0];
                RUN_OFFSET:    run_d  = pwdata[1:0];
                COUNT0_OFFSET: cnt0_d = pwdata[15:0];
                COUNT1_OFFSET: cnt1_d = pwdata[15:0];
                default: begin
                end
            endcase
        end

        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (rd_setup) begin
            pslverr_d = ~hit;
            case (paddr)
                MODE_OFFSET:   prdata_d = {24'h000000, mode_q};
                RUN_OFFSET:    prdata_d = {30'h00000000, run_q};
                OVF_OFFSET:    prdata_d = {30'h00000000, ovf_q};
                COUNT0_OFFSET: prdata_d = {16'h0000, cnt0_q};
                COUNT1_OFFSET: prdata_d = {16'h0000, cnt1_q};
                default:       prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q    <= MODE_RESET;
            run_q     <= RUN_RESET;
            ovf_q     <= OVF_RESET;
            cnt0_q    <= COUNT_RESET;
            cnt1_q    <= COUNT_RESET;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            run_q     <= run_d;
            ovf_q     <= ovf_d;
            cnt0_q    <= cnt0_d;
            cnt1_q    <= cnt1_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Zero wait states: data latched in setup, presented in the access phase
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & psel & penable;

    logic no_wr;
    assign no_wr = ~wr_acc;

    property p_wide_timer;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode0 == MODE_WIDE && !mode_q[COUNT_SEL_POS] && go[0] && mc_tick && no_wr)
        |=> cnt0_q == 16'($past(cnt0_q) + 16'h0001);
    endproperty
    a_wide_timer: assert property (p_wide_timer) else $error("wide timer missed a step");

    property p_reload;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode0 == MODE_RELOAD && tick[0] && cnt0_q[7:0] == 8'hFF && no_wr)
        |=> cnt0_q[7:0] == cnt0_q[15:8] && ovf_q[UNIT0_POS];
    endproperty
    a_reload: assert property (p_reload) else $error("reload not taken");

    property p_prescale;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode0 == MODE_PRESCALE && tick[0] && cnt0_q[4:0] == PRESCALE_MAX && no_wr)
        |=> cnt0_q[4:0] == 5'h00 && cnt0_q[15:8] == 8'($past(cnt0_q[15:8]) + 8'h01);
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler carry wrong");

    property p_split_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode1 == MODE_SPLIT && no_wr) |=> $stable(cnt1_q);
    endproperty
    a_split_stop: assert property (p_split_stop) else $error("timer 1 ran in mode 3");

    property p_split_hi;
        @(posedge sys_clk) disable iff (!rst_n)
        (split && run_q[UNIT1_POS] && mc_tick && no_wr)
        |=> cnt0_q[15:8] == 8'($past(cnt0_q[15:8]) + 8'h01);
    endproperty
    a_split_hi: assert property (p_split_hi) else $error("split high byte stalled");

    property p_counter_edge;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q[COUNT_SEL_POS] && !fall[0] && !tick0_hi && no_wr) |=> $stable(cnt0_q);
    endproperty
    a_counter_edge: assert property (p_counter_edge) else $error("count without edge");

    property p_edge_rate;
        @(posedge sys_clk) disable iff (!rst_n)
        fall[0] |-> ##12 (mc_tick && !fall[0]);
    endproperty
    a_edge_rate: assert property (p_edge_rate) else $error("edges too close");

    property p_gate;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q[GATE_EN_POS] && !pin_sync_q[2]) |-> !tick[0];
    endproperty
    a_gate: assert property (p_gate) else $error("counted with gate low");

    property p_gate_one;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q[TIMER1_FIELD_POS+GATE_EN_POS] && !pin_sync_q[3]) |-> !tick[1];
    endproperty
    a_gate_one: assert property (p_gate_one) else $error("unit 1 counted with gate low");

    property p_mc_period;
        @(posedge sys_clk) disable iff (!rst_n)
        mc_tick |=> !mc_tick ##11 mc_tick;
    endproperty
    a_mc_period: assert property (p_mc_period) else $error("machine cycle not 12 clocks");

    property p_counter_edge_one;
        @(posedge sys_clk) disable iff (!rst_n)
        (mode_q[TIMER1_FIELD_POS+COUNT_SEL_POS] && !fall[1] && no_wr) |=> $stable(cnt1_q);
    endproperty
    a_counter_edge_one: assert property (p_counter_edge_one) else $error("unit 1 count without edge");

    property p_edge_rate_one;
        @(posedge sys_clk) disable iff (!rst_n)
        fall[1] |-> ##12 (mc_tick && !fall[1]);
    endproperty
    a_edge_rate_one: assert property (p_edge_rate_one) else $error("unit 1 edges too close");
endmodule : dtc_timer_counter

//--- dv/dtc_pin_source.sv
// Behavioural source for the count and gate pins of both units.
// Assumes it shares sys_clk with the timer block and is steered by task calls.
`timescale 1ns/1ps
module dtc_pin_source (
    input  wire logic sys_clk,
    output logic      count_input_zero,
    output logic      count_input_one,
    output logic      gate_input_zero,
    output logic      gate_input_one
);
    // Count pins idle high so that release of reset shows no edge
    initial begin
        count_input_zero = 1'b1;
        count_input_one  = 1'b1;
        gate_input_zero  = 1'b0;
        gate_input_one   = 1'b0;
    end

    // Each level stands half cycles; callers keep half at 12 or more
    task automatic pulses(input int unit, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge sys_clk);
            if (unit == 0) count_input_zero <= 1'b0;
            else count_input_one <= 1'b0;
            repeat (half) @(posedge sys_clk);
            if (unit == 0) count_input_zero <= 1'b1;
            else count_input_one <= 1'b1;
        end
    endtask : pulses

    task automatic set_gate(input int unit, input logic lvl);
        @(posedge sys_clk);
        if (unit == 0) gate_input_zero <= lvl;
        else gate_input_one <= lvl;
    endtask : set_gate
endmodule : dtc_pin_source

//--- dv/tb_dual_timer_counter.sv
// Self-checking bench for the dual timer/counter over APB.
// Assumes zero-wait APB and a 12-clock machine cycle from the package.
`timescale 1ns/1ps
module tb_dual_timer_counter;
    import dtc_pkg::*;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        cz, co, gz, go;
    int          mismatches, checks;
    logic [7:0]  md   [5] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h02};
    logic [15:0] pre  [5] = '{16'h001F, 16'h00FE, 16'hFFFF, 16'hA0FE, 16'h5510};
    logic [15:0] post [5] = '{16'h0100, 16'h0101, 16'h0000, 16'hA0A0, 16'h5513};
    int          kmc  [5] = '{1, 3, 1, 2, 3};
    logic [1:0]  ovf  [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0};

    dtc_timer_counter dtc_timer_counter_inst (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_input_zero(cz), .count_input_one(co),
        .gate_input_zero(gz), .gate_input_one(go));
    dtc_pin_source dtc_pin_source_inst (.sys_clk(sys_clk), .count_input_zero(cz),
        .count_input_one(co), .gate_input_zero(gz), .gate_input_one(go));

    initial begin
        sys_clk = 1'b0;
        forever #(SYS_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, rdat, exp);
    endtask : rd

    // Write effects land 12*k clocks apart, so exactly k ticks see run high
    task automatic run_mc(input logic [1:0] mask, input int k);
        apb(1'b1, RUN_OFFSET, {30'h0, mask});
        repeat (OSC_PER_MACHINE * k - 3) @(posedge sys_clk);
        apb(1'b1, RUN_OFFSET, 32'h0);
    endtask : run_mc

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (10000) @(posedge sys_clk);
        mismatches++;
        $display("[FAIL] watchdog expired");
        end_sim();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(MODE_OFFSET, {24'h0, MODE_RESET}, "mode reset");
        rd(RUN_OFFSET, {30'h0, RUN_RESET}, "run reset");
        rd(OVF_OFFSET, {30'h0, OVF_RESET}, "ovf reset");
        rd(COUNT0_OFFSET, {16'h0, COUNT_RESET}, "count0 reset");
        rd(COUNT1_OFFSET, {16'h0, COUNT_RESET}, "count1 reset");
        rd(8'h14, 32'h0, "unmapped read");
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        $display("test reset done");
        // Same table on both units; unit 1 fields sit four bits higher
        for (int u = 0; u < 2; u++) begin
            for (int i = 0; i < 5; i++) begin
                apb(1'b1, MODE_OFFSET, {24'h0, md[i] << (4 * u)});
                apb(1'b1, COUNT0_OFFSET + 8'(4 * u), {16'h0, pre[i]});
                run_mc(2'(1 << u), kmc[i]);
                rd(COUNT0_OFFSET + 8'(4 * u), {16'h0, post[i]}, "mode count");
                rd(OVF_OFFSET, {30'h0, ovf[i] << u}, "overflow");
                apb(1'b1, OVF_OFFSET, 32'h3);
                rd(OVF_OFFSET, 32'h0, "overflow cleared");
            end
        end
        $display("test modes done");
        apb(1'b1, MODE_OFFSET, 32'h33);
        apb(1'b1, COUNT0_OFFSET, 32'h0);
        apb(1'b1, COUNT1_OFFSET, 32'h0);
        run_mc(2'h3, 3);
        rd(COUNT0_OFFSET, 32'h0303, "split halves");
        rd(COUNT1_OFFSET, 32'h0, "split stops unit 1");
        $display("test split done");
        // Fastest legal source rate: twelve clocks per level
        for (int u = 0; u < 2; u++) begin
            apb(1'b1, MODE_OFFSET, {24'h0, 8'h05 << (4 * u)});
            apb(1'b1, COUNT0_OFFSET + 8'(4 * u), 32'h0);
            apb(1'b1, RUN_OFFSET, {30'h0, 2'(1 << u)});
            dtc_pin_source_inst.pulses(u, 4, 12);
            repeat (16) @(posedge sys_clk);
            rd(COUNT0_OFFSET + 8'(4 * u), 32'h4, "edge count");
        end
        $display("test counter done");
        for (int u = 0; u < 2; u++) begin
            apb(1'b1, MODE_OFFSET, {24'h0, 8'h09 << (4 * u)});
            apb(1'b1, COUNT0_OFFSET + 8'(4 * u), 32'h0);
            run_mc(2'(1 << u), 2);
            rd(COUNT0_OFFSET + 8'(4 * u), 32'h0, "gate low holds");
            dtc_pin_source_inst.set_gate(u, 1'b1);
            repeat (30) @(posedge sys_clk);
            run_mc(2'(1 << u), 2);
            rd(COUNT0_OFFSET + 8'(4 * u), 32'h2, "gate high counts");
            dtc_pin_source_inst.set_gate(u, 1'b0);
        end
        $display("test gate done");
        end_sim();
    end
endmodule : tb_dual_timer_counter
